//--- design/cps_sequencer.sv
// Instruction sequencer core: four-phase cycle, fetch/execute overlap,
// program counter, return stack control, ALU and status flags.
// Assumes synchronous program and data memories with one cycle of latency.
//
// Added by the designer: the placing of the registers and the plain strobed port.
`timescale 1ns/100ps
`default_nettype none
`include "cps_map.svh"
module cps_sequencer (
    input  wire logic        clk_sys,
    input  wire logic        reset_n,
    output logic [11:0]      pmAddr,
    input  wire logic [15:0] pmData,
    output logic [7:0]       dmAddr,
    input  wire logic [7:0]  dmRdData,
    output logic [7:0]       dmWrData,
    output logic             dmWrEn,
    input  wire logic        irqReq,
    output logic             irqAck,
    output logic [1:0]       instrPhase,
    input  wire logic [3:0]  regAddr,
    input  wire logic [15:0] regWrData,
    input  wire logic        regWr,
    input  wire logic        regRd,
    output logic [15:0]      regRdData
);
    cps_pkg::cps_core_s st_q;
    cps_pkg::cps_core_s st_d;
    cps_stack_if        stk ();

    logic [3:0]  op;
    logic [3:0]  subOp;
    logic [9:0]  aluOut;
    logic [7:0]  aluRes;
    logic [7:0]  memData;
    logic        run;
    logic        execNow;
    logic        execValid;
    logic        memWrite;
    logic        toPcl;
    logic        skipHit;
    logic        ctlFlush;
    logic        irqRise;
    logic        irqTake;
    logic        aluClass;
    logic        addSub;
    logic        rotThru;
    logic        rotPlain;

    // ==========================================================================
    // ALU
    // Returns {overflow, carry, result}; carry of a subtract means no borrow
    function automatic logic [9:0] aluCalc(
        input logic [3:0] code,
        input logic [7:0] a,
        input logic [7:0] b,
        input logic       cin
    );
        logic [8:0] sum;
        logic [7:0] bb;
        logic       c0;
        logic [7:0] r;
        logic       co;
        sum = 9'h000;
        bb  = b;
        c0  = 1'b0;
        r   = 8'h00;
        co  = cin;
        unique case (code)
            `CPS_ALU_ADD, `CPS_ALU_ADC, `CPS_ALU_SUB, `CPS_ALU_SBC: begin
                bb  = code[1] ? ~b : b;
                c0  = (code == `CPS_ALU_SUB) ? 1'b1 :
                      (code == `CPS_ALU_ADD) ? 1'b0 : cin;
                sum = {1'b0, a} + {1'b0, bb} + {8'h00, c0};
                r   = sum[7:0];
                co  = sum[8];
            end
            `CPS_ALU_AND:  r = a & b;
            `CPS_ALU_OR:   r = a | b;
            `CPS_ALU_XOR:  r = a ^ b;
            `CPS_ALU_CPL:  r = ~b;
            `CPS_ALU_RR:   r = {b[0], b[7:1]};
            `CPS_ALU_RL:   r = {b[6:0], b[7]};
            `CPS_ALU_RRC: begin
                r  = {cin, b[7:1]};
                co = b[0];
            end
            `CPS_ALU_RLC: begin
                r  = {b[6:0], cin};
                co = b[7];
            end
            `CPS_ALU_INC:  r = b + 8'h01;
            `CPS_ALU_DEC:  r = b - 8'h01;
            `CPS_ALU_PASS: r = b;
            default:       r = 8'h00;                 // Code f is unused
        endcase
        return {(a[7] == bb[7]) && (r[7] != a[7]), co, r};
    endfunction

    // ==========================================================================
    // Decode of the word in execution
    assign op       = st_q.ir[15:12];
    assign subOp    = (op == `CPS_OP_SIZ) ? `CPS_ALU_INC :
                      (op == `CPS_OP_SDZ) ? `CPS_ALU_DEC : st_q.ir[11:8];
    assign aluOut   = aluCalc(subOp, st_q.acc, st_q.opnd, st_q.flags.carry);
    assign aluRes   = aluOut[7:0];
    assign aluClass = (op == `CPS_OP_ALUA) || (op == `CPS_OP_ALUM);
    assign addSub   = subOp <= `CPS_ALU_SBC;
    assign rotThru  = (subOp == `CPS_ALU_RRC) || (subOp == `CPS_ALU_RLC);
    assign rotPlain = (subOp == `CPS_ALU_RR) || (subOp == `CPS_ALU_RL);

    // Execution happens on the last phase of a running cycle
    assign run       = st_q.ctrl[`CPS_CTRL_RUN];
    assign execNow   = run && (st_q.phase == cps_pkg::PH_T4);
    assign execValid = execNow && st_q.irValid;

    // Writes that target the data side, low counter byte included
    assign memWrite = execValid && (op inside {`CPS_OP_ALUM, `CPS_OP_MOVAM,
                                               `CPS_OP_SIZ, `CPS_OP_SDZ});
    assign memData  = (op == `CPS_OP_MOVAM) ? st_q.acc : aluRes;
    assign toPcl    = st_q.ir[7:0] == `CPS_PCL_DADDR;

    // Branch decisions come out of the ALU result or the operand
    assign skipHit = execValid &&
        (((op == `CPS_OP_SZ) && (st_q.opnd == 8'h00)) ||
         ((op == `CPS_OP_SNZ) && (st_q.opnd != 8'h00)) ||
         (((op == `CPS_OP_SIZ) || (op == `CPS_OP_SDZ)) && (aluRes == 8'h00)));

    // Any change of flow discards the prefetched word
    assign ctlFlush = skipHit || (memWrite && toPcl) ||
        (execValid && (op inside {`CPS_OP_JUMP, `CPS_OP_CALL,
                                  `CPS_OP_RET, `CPS_OP_INTERRUPT_RETURN}));

    // Interrupt edge, latched until taken; a full stack holds it back
    assign irqRise = st_q.irqSync2 && !st_q.irqDly;
    assign irqTake = execNow && !ctlFlush && st_q.irqPend &&
                     st_q.intEn && st_q.ctrl[`CPS_CTRL_IRQEN] && !stk.full;

    // ==========================================================================
    // Next state
    // Interrupts are only taken where the flow is sequential, so the
    // pushed address is always the word that was going to run next.
    always_comb begin
        st_d          = st_q;
        st_d.dmWrEn   = 1'b0;
        st_d.irqAck   = 1'b0;
        st_d.rdData   = 16'h0000;
        stk.push      = 1'b0;
        stk.pop       = 1'b0;
        stk.pushData  = st_q.pc - 12'h001;
        // Request pin is asynchronous; two stages before use
        st_d.irqSync1 = irqReq;
        st_d.irqSync2 = st_q.irqSync1;
        st_d.irqDly   = st_q.irqSync2;
        // New edge wins over the clear by acknowledge
        st_d.irqPend  = irqRise || (st_q.irqPend && !irqTake);

        // Register port: control writes, state reads one cycle later
        if (regWr && regAddr == `CPS_REG_CTRL) begin
            st_d.ctrl = regWrData[1:0];
        end
        if (regRd) begin
            unique case (regAddr)
                `CPS_REG_CTRL:   st_d.rdData = {14'h0000, st_q.ctrl};
                `CPS_REG_PCSTAT: st_d.rdData = {st_q.irqPend, 3'h0, st_q.pc};
                `CPS_REG_CORE:   st_d.rdData = {5'h00, st_q.flags, st_q.acc};
                default:         st_d.rdData = 16'h0000;
            endcase
        end

        if (run) begin
            unique case (st_q.phase)
                cps_pkg::PH_T1: begin
                    st_d.phase  = cps_pkg::PH_T2;
                    st_d.pmAddr = st_q.pc;
                    st_d.pc     = st_q.pc + 12'h001;
                    st_d.dmAddr = st_q.ir[7:0];
                end
                cps_pkg::PH_T2: begin
                    st_d.phase = cps_pkg::PH_T3;
                end
                cps_pkg::PH_T3: begin
                    st_d.phase   = cps_pkg::PH_T4;
                    st_d.fetched = pmData;
                    // Only the low counter byte is visible as data
                    st_d.opnd = (st_q.dmAddr == `CPS_PCL_DADDR) ?
                                st_q.pc[7:0] : dmRdData;
                end
                cps_pkg::PH_T4: begin
                    st_d.phase   = cps_pkg::PH_T1;
                    st_d.ir      = st_q.fetched;
                    st_d.irValid = !(ctlFlush || irqTake);
                    if (st_q.irValid) begin
                        unique case (op)
                            `CPS_OP_ALUA:  st_d.acc = aluRes;
                            `CPS_OP_MOVLA: st_d.acc = st_q.ir[7:0];
                            `CPS_OP_JUMP:  st_d.pc = st_q.ir[11:0];
                            `CPS_OP_CALL: begin
                                st_d.pc  = st_q.ir[11:0];
                                stk.push = 1'b1;
                            end
                            `CPS_OP_RET: begin
                                st_d.pc = stk.topData;
                                stk.pop = 1'b1;
                            end
                            `CPS_OP_INTERRUPT_RETURN: begin
                                st_d.pc    = stk.topData;
                                stk.pop    = 1'b1;
                                st_d.intEn = 1'b1;
                            end
                            default: ;
                        endcase
                        // Status: rotates without carry leave flags alone
                        if (aluClass && !rotPlain) begin
                            st_d.flags.zero = aluRes == 8'h00;
                            if (addSub || rotThru) begin
                                st_d.flags.carry = aluOut[8];
                            end
                            if (addSub) begin
                                st_d.flags.ovf = aluOut[9];
                            end
                        end
                    end
                    // Low byte write jumps inside the present page
                    if (memWrite && toPcl) begin
                        st_d.pc = {st_q.pc[11:8], memData};
                    end else if (memWrite) begin
                        st_d.dmWrEn   = 1'b1;
                        st_d.dmWrData = memData;
                    end
                    if (irqTake) begin
                        stk.push    = 1'b1;
                        st_d.pc     = `CPS_IRQ_VECTOR;
                        st_d.intEn  = 1'b0;
                        st_d.irqAck = 1'b1;
                    end
                end
            endcase
        end
    end

    // Reset starts from address zero with an empty pipeline slot
    always_ff @(posedge clk_sys) begin
        if (!reset_n) begin
            st_q         <= '0;
            st_q.pc      <= `CPS_PC_RESET;
            st_q.intEn   <= 1'b1;
            st_q.ctrl    <= `CPS_CTRL_RESET;
        end else begin
            st_q <= st_d;
        end
    end

    // ==========================================================================
    // Return stack; its pointer never reaches the register port
    cps_return_stack #(
        .DEPTH   (`CPS_STK_LEVELS)
    ) u_stack (
        .clk_sys (clk_sys),
        .reset_n (reset_n),
        .stk     (stk)
    );

    // ==========================================================================
    // Outputs
    assign pmAddr     = st_q.pmAddr;
    assign dmAddr     = st_q.dmAddr;
    assign dmWrData   = st_q.dmWrData;
    assign dmWrEn     = st_q.dmWrEn;
    assign irqAck     = st_q.irqAck;
    assign instrPhase = st_q.phase;
    assign regRdData  = st_q.rdData;

    // ==========================================================================
    // Checks
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!reset_n);

    sequence seqRunCycle;
        run && st_q.phase == cps_pkg::PH_T1 ##1 run [*3];
    endsequence
    sequence seqJump;
        execValid && op == `CPS_OP_JUMP;
    endsequence
    sequence seqDummy;
        !st_q.irValid ##4 st_q.pmAddr == $past(st_q.ir[11:0], 5);
    endsequence

    chk_phase_walk: assert property (seqRunCycle |->
        st_q.phase == cps_pkg::PH_T4 && $past(st_q.phase) == cps_pkg::PH_T3 &&
        $past(st_q.phase, 2) == cps_pkg::PH_T2 ##1 st_q.phase == cps_pkg::PH_T1)
        else $error("phases did not walk one to four");
    chk_pc_fetch: assert property (
        run && st_q.phase == cps_pkg::PH_T1 |=>
            st_q.pmAddr == $past(st_q.pc) && st_q.pc == $past(st_q.pc) + 12'h001)
        else $error("fetch did not use and advance the counter");
    chk_jump_flush: assert property (seqJump |=> seqDummy)
        else $error("jump did not flush and fetch its target");
    chk_call_push: assert property (
        execValid && op == `CPS_OP_CALL |->
            stk.push && stk.pushData == st_q.pc - 12'h001)
        else $error("call did not push the return address");
    chk_skip_dummy: assert property (
        execValid && op == `CPS_OP_SZ && st_q.opnd == 8'h00 |=> !st_q.irValid)
        else $error("met skip did not insert a dummy cycle");
    chk_pcl_page: assert property (
        execValid && op == `CPS_OP_MOVAM && toPcl |=> !st_q.irValid &&
            st_q.pc == {$past(st_q.pc[11:8]), $past(st_q.acc)} && !st_q.dmWrEn)
        else $error("low byte write did not jump in page");
    chk_irq_hold: assert property (
        st_q.irqPend && stk.full |=> !st_q.irqAck ##0 st_q.irqPend)
        else $error("interrupt acknowledged with a full stack");
    chk_ret_pop: assert property (
        execValid && op == `CPS_OP_RET |-> stk.pop ##1 st_q.pc == $past(stk.topData))
        else $error("return did not restore the counter");
    chk_reset_pc: assert property (!$past(reset_n) |-> st_q.pc == `CPS_PC_RESET)
        else $error("counter not zero after reset");

    // Pipeline and datapath checks
    // Entry loads the vector, acknowledges and leaves a dummy slot
    chk_irq_entry: assert property (irqTake |-> stk.push ##1
        st_q.irqAck && st_q.pc == `CPS_IRQ_VECTOR && !st_q.irValid)
        else $error("interrupt entry did not load the vector");
    // Add through the accumulator, held against plain arithmetic
    chk_add_acc: assert property (
        execValid && op == `CPS_OP_ALUA && subOp == `CPS_ALU_ADD |=>
            st_q.acc == 8'($past(st_q.acc) + $past(st_q.opnd)) &&
            st_q.flags.zero == (st_q.acc == 8'h00))
        else $error("add did not update accumulator and zero flag");
    // A sequential slot keeps the counter and the next word valid
    chk_seq_slot: assert property (
        execNow && !ctlFlush && !irqTake |=>
            st_q.irValid && st_q.pc == $past(st_q.pc))
        else $error("plain instruction did not keep the pipeline full");
    // Decode sees a new word only at the end of a cycle
    chk_ir_hold: assert property (
        st_q.phase != cps_pkg::PH_T4 |=> st_q.ir == $past(st_q.ir))
        else $error("instruction changed outside the last phase");
    // Reading the low counter byte gives the counter, not memory
    chk_pcl_read: assert property (
        run && st_q.phase == cps_pkg::PH_T3 && st_q.dmAddr == `CPS_PCL_DADDR |=>
            st_q.opnd == $past(st_q.pc[7:0]))
        else $error("low counter byte read did not return the counter");
endmodule
`default_nettype wire

//--- include/cps_map.svh
// Constants of the program sequencer: register port map, field positions,
// opcode and ALU codes, reset values and addresses.
// Assumes inclusion by the sequencer package users; definitions only.
// Operation
// - System clock is split into four phases; four phases form one cycle
// - Phase one advances the program counter and fetches the next word
// - Phases one to four decode and execute the previously fetched word
// - Fetch overlaps execution, giving one plain instruction per cycle
// - Jump and call take two cycles; the prefetched word is flushed
// - Program counter steps by one unless control moves elsewhere
// - Program counter is twelve bits: four upper bits and a low byte
// - Only the low byte of the program counter is program reachable
// - Jumps, calls, interrupt entry and reset load a destination address
// - A met skip condition discards the prefetched word for a dummy cycle
// - Low byte is read/write; a write jumps in the page with a dummy cycle
// - Return stack holds eight counter values, invisible to software
// - The stack pointer is neither readable nor writable by software
// - Call or interrupt acknowledge pushes the program counter
// - Subroutine or interrupt return pops the saved counter value
// - After reset the stack pointer shows an empty stack
// - With a full stack an interrupt is latched but not acknowledged
// - A call on a full stack proceeds and loses the oldest entry
// - An eight-bit ALU does arithmetic, logic, rotate and branch tests
// - ALU result goes to its target; flags are updated except by plain rotates and SIZ/SDZ
// - After reset the program counter is zero
`ifndef CPS_MAP_SVH
`define CPS_MAP_SVH
// ==========================================================================
// Register port
`define CPS_REG_CTRL   4'h0
`define CPS_REG_PCSTAT 4'h4
`define CPS_REG_CORE   4'h8
`define CPS_CTRL_RUN   0
`define CPS_CTRL_IRQEN 1
`define CPS_CTRL_RESET 2'h3
// ==========================================================================
// Datapath
`define CPS_PC_RESET   12'h000
`define CPS_IRQ_VECTOR 12'h004
`define CPS_PCL_DADDR  8'h02
`define CPS_STK_LEVELS 8
// ==========================================================================
// Opcode classes in instruction bits 15:12
`define CPS_OP_NOP   4'h0
`define CPS_OP_ALUA  4'h1
`define CPS_OP_ALUM  4'h2
`define CPS_OP_MOVLA 4'h3
`define CPS_OP_MOVAM 4'h4
`define CPS_OP_JUMP  4'h5
`define CPS_OP_CALL  4'h6
`define CPS_OP_RET   4'h7
`define CPS_OP_INTERRUPT_RETURN  4'h8
`define CPS_OP_SZ    4'h9
`define CPS_OP_SNZ   4'ha
`define CPS_OP_SIZ   4'hb
`define CPS_OP_SDZ   4'hc
// ALU codes in instruction bits 11:8
`define CPS_ALU_ADD  4'h0
`define CPS_ALU_ADC  4'h1
`define CPS_ALU_SUB  4'h2
`define CPS_ALU_SBC  4'h3
`define CPS_ALU_AND  4'h4
`define CPS_ALU_OR   4'h5
`define CPS_ALU_XOR  4'h6
`define CPS_ALU_CPL  4'h7
`define CPS_ALU_RR   4'h8
`define CPS_ALU_RL   4'h9
`define CPS_ALU_RRC  4'ha
`define CPS_ALU_RLC  4'hb
`define CPS_ALU_INC  4'hc
`define CPS_ALU_DEC  4'hd
`define CPS_ALU_PASS 4'he
`endif

//--- include/cps_pkg.sv
// Types of the program sequencer.
// Assumes compilation before the interface and design files.
`default_nettype none
package cps_pkg;
    typedef enum logic [1:0] {PH_T1, PH_T2, PH_T3, PH_T4} cps_phase_e;
    typedef struct packed {
        logic carry;
        logic zero;
        logic ovf;
    } cps_flags_s;
    typedef struct packed {
        cps_phase_e  phase;
        logic [11:0] pc;
        logic [11:0] pmAddr;
        logic [15:0] fetched;
        logic [15:0] ir;
        logic        irValid;
        logic [7:0]  acc;
        cps_flags_s  flags;
        logic [7:0]  opnd;
        logic [7:0]  dmAddr;
        logic [7:0]  dmWrData;
        logic        dmWrEn;
        logic        irqSync1;
        logic        irqSync2;
        logic        irqDly;
        logic        irqPend;
        logic        intEn;
        logic        irqAck;
        logic [1:0]  ctrl;
        logic [15:0] rdData;
    } cps_core_s;
endpackage
`default_nettype wire

//--- include/cps_stack_if.sv
// Push/pop link between the sequencer core and its return stack.
// Assumes one core and one stack on the same clock.
`timescale 1ns/100ps
`default_nettype none
interface cps_stack_if;
    logic        push;
    logic        pop;
    logic [11:0] pushData;
    logic [11:0] topData;
    logic        full;
    modport core  (output push, output pop, output pushData,
                   input topData, input full);
    modport store (input push, input pop, input pushData,
                   output topData, output full);
endinterface
`default_nettype wire

//--- design/cps_return_stack.sv
// Hardware return stack of the sequencer, circular, no software access.
// Assumes push and pop never come in the same cycle.
`timescale 1ns/100ps
`default_nettype none
`include "cps_map.svh"
module cps_return_stack #(
    parameter int DEPTH = `CPS_STK_LEVELS
) (
    input  wire logic   clk_sys,
    input  wire logic   reset_n,
    cps_stack_if.store  stk
);
    localparam int PW = $clog2(DEPTH);
    typedef struct packed {
        logic [PW-1:0]           ptr;
        logic [PW:0]             cnt;
        logic [DEPTH-1:0][11:0]  mem;
    } cps_stk_s;
    cps_stk_s st_q;
    cps_stk_s st_d;
    // ==========================================================================
    // Storage: pointer and count are internal only
    assign stk.topData = st_q.mem[st_q.ptr - PW'(1)];
    assign stk.full    = st_q.cnt == (PW+1)'(DEPTH);
    // Push overwrites the oldest slot when full, so the count saturates
    always_comb begin
        st_d = st_q;
        if (stk.push) begin
            st_d.mem[st_q.ptr] = stk.pushData;
            st_d.ptr = st_q.ptr + PW'(1);
            if (!stk.full) begin
                st_d.cnt = st_q.cnt + (PW+1)'(1);
            end
        end else if (stk.pop && st_q.cnt != '0) begin
            st_d.ptr = st_q.ptr - PW'(1);
            st_d.cnt = st_q.cnt - (PW+1)'(1);
        end
    end
    // Reset leaves an empty stack and clears the stored contents as well
    always_ff @(posedge clk_sys) begin
        if (!reset_n) begin
            st_q <= '0;
        end else begin
            st_q <= st_d;
        end
    end
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!reset_n);
    chk_overflow_keep: assert property (stk.full && stk.push |=> stk.full ##0
        stk.topData == $past(stk.pushData))
        else $error("overflowing push did not keep stack full with new top");
    chk_reset_empty: assert property (!$past(reset_n) |-> st_q.cnt == '0)
        else $error("stack not empty after reset");
endmodule
`default_nettype wire

//--- tb/cps_mem_model.sv
// Program ROM and data RAM beside the sequencer, one cycle of read latency.
// Assumes the bench fills both arrays before reset is released.
`timescale 1ns/100ps
`default_nettype none
module cps_mem_model (
    input  wire logic        clk_sys,
    input  wire logic [11:0] pmAddr,
    output logic [15:0]      pmData,
    input  wire logic [7:0]  dmAddr,
    output logic [7:0]       dmRdData,
    input  wire logic [7:0]  dmWrData,
    input  wire logic        dmWrEn
);
    logic [15:0] rom [4096];
    logic [7:0]  ram [256];
    // ==========================================================
    // Synchronous reads; data stays valid until the next edge
    always @(posedge clk_sys) begin
        pmData <= rom[pmAddr];
        dmRdData <= ram[dmAddr];
        if (dmWrEn) ram[dmAddr] <= dmWrData;
    end
endmodule
`default_nettype wire

//--- tb/cpu_program_sequencer_bench.sv
// Self-checking bench: runs a short program and compares data writes.
// Assumes cps_mem_model as program and data memory.
`timescale 1ns/100ps
`default_nettype none
`include "cps_map.svh"
module cpu_program_sequencer_bench;
    logic        clk_sys = 1'b0;
    logic        reset_n = 1'b0;
    logic [11:0] pmAddr;
    logic [15:0] pmData, regRdData;
    logic [7:0]  dmAddr, dmRdData, dmWrData;
    logic        dmWrEn, irqAck, irqReq = 1'b0, regWr = 1'b0, regRd = 1'b0;
    logic [1:0]  instrPhase;
    logic [3:0]  regAddr = 4'h0;
    logic [15:0] regWrData = 16'h0000;
    integer      seed = 32'h1689;
    int          mismatches = 0, n_tests = 0, nW = 0, nAck = 0, cyc = 0, t0 = 0, ic = -2, k;
    int          dm[256];
    logic [23:0] expQ[$], e;
    // Address and word of each program location; the rest hold no-ops
    // The tail jumps into a self-call at 0x40 that fills and overflows the stack
    logic [27:0] prog[15] = '{28'h0003005, 28'h0014010, 28'h0026020, 28'h0034011,
        28'h0043009, 28'h0054002, 28'h0063077, 28'h0094013, 28'h00a0000, 28'h00b5040,
        28'h0201010, 28'h0219012, 28'h02230ff, 28'h0237000, 28'h0406040};
    cps_sequencer dut_u (.clk_sys(clk_sys), .reset_n(reset_n), .pmAddr(pmAddr),
        .pmData(pmData), .dmAddr(dmAddr), .dmRdData(dmRdData), .dmWrData(dmWrData),
        .dmWrEn(dmWrEn), .irqReq(irqReq), .irqAck(irqAck), .instrPhase(instrPhase),
        .regAddr(regAddr), .regWrData(regWrData), .regWr(regWr), .regRd(regRd),
        .regRdData(regRdData));
    cps_mem_model mem_u (.clk_sys(clk_sys), .pmAddr(pmAddr), .pmData(pmData),
        .dmAddr(dmAddr), .dmRdData(dmRdData), .dmWrData(dmWrData), .dmWrEn(dmWrEn));
    always #20 clk_sys = ~clk_sys;
    // ==========================================================
    // Helpers
    task automatic check(input string what, input logic [23:0] seen, input logic [23:0] ex);
        n_tests++;
        if (seen !== ex) begin
            mismatches++;
            $display("Error %s expected %h seen %h", what, ex, seen);
        end
    endtask
    task automatic summarize();
        $display("Comparisons %0d mismatches %0d", n_tests, mismatches);
        if (mismatches == 0 && n_tests > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask
    task automatic regWrite(input logic [3:0] a, input logic [15:0] d);
        @(posedge clk_sys);
        regAddr <= a;
        regWrData <= d;
        regWr <= 1'b1;
        @(posedge clk_sys);
        regWr <= 1'b0;
    endtask
    task automatic regRead(input logic [3:0] a, input logic [15:0] d, input logic [15:0] m);
        @(posedge clk_sys);
        regAddr <= a;
        regRd <= 1'b1;
        @(posedge clk_sys);
        regRd <= 1'b0;
        #1 check("read data", 24'(regRdData & m), 24'(d));
    endtask
    // Reference run on integers; a flow change costs one extra cycle
    task automatic run_model(input int pc0, input int steps);
        int pc, acc, n;
        int stk[$];
        logic [15:0] w;
        pc = pc0;
        acc = 0;
        for (n = 0; n < steps; n++) begin
            w = mem_u.rom[pc];
            pc = pc + 1;
            ic = ic + 1;
            case (w[15:12])
                4'h1: acc = (acc + dm[w[7:0]]) % 256;
                4'h3: acc = w[7:0];
                4'h4: if (w[7:0] == `CPS_PCL_DADDR) begin
                    pc = (pc & 32'hf00) | acc;
                    ic = ic + 1;
                end else begin
                    dm[w[7:0]] = acc;
                    expQ.push_back({ic[7:0], w[7:0], acc[7:0]});
                end
                4'h5, 4'h6: begin
                    if (w[15:12] == 4'h6) stk.push_back(pc);
                    pc = w[11:0];
                    ic = ic + 1;
                end
                4'h7: begin
                    pc = stk.pop_back();
                    ic = ic + 1;
                end
                4'h9: if (dm[w[7:0]] == 0) begin
                    pc = pc + 1;
                    ic = ic + 1;
                end
                default: ;
            endcase
        end
    endtask
    // ==========================================================
    // Monitor on the falling edge, where the registered outputs have settled
    always @(negedge clk_sys) begin
        cyc = cyc + 1;
        if (irqAck === 1'b1) nAck++;
        if (dmWrEn === 1'b1) begin
            if (nW == 0) t0 = cyc;
            e = expQ.pop_front();
            check("write", {8'h0, dmAddr, dmWrData}, {8'h0, e[15:0]});
            if (nW < 3) check("cycle", 24'((cyc - t0) / 4), 24'(e[23:16]));
            check("phase", 24'(instrPhase), 24'h0);
            nW++;
        end
    end
    initial begin
        #400000;
        mismatches++;
        summarize();
    end
    initial begin
        for (k = 0; k < 4096; k++) mem_u.rom[k] = 16'h0000;
        for (k = 0; k < 256; k++) mem_u.ram[k] = 8'h00;
        foreach (prog[i]) mem_u.rom[prog[i][27:16]] = prog[i][15:0];
        run_model(0, 10);
        repeat (16) @(posedge clk_sys);
        check("reset pc", 24'(pmAddr), 24'h0);
        check("reset phase", 24'(instrPhase), 24'h0);
        reset_n <= 1'b1;
        regRead(`CPS_REG_CTRL, 16'h0003, 16'hffff);
        regRead(4'(4'h1 + 4'h4 * ($unsigned($random(seed)) % 3)), 16'h0000, 16'hffff);
        regWrite(`CPS_REG_PCSTAT, 16'hffff);
        for (k = 0; k < 300 && nW < 3; k++) @(posedge clk_sys);
        regRead(`CPS_REG_CORE, 16'h0009, 16'hffff);
        run_model(4, 3);
        @(posedge clk_sys);
        irqReq <= 1'b1;
        for (k = 0; k < 100 && irqAck !== 1'b1; k++) @(negedge clk_sys);
        check("ack", 24'(irqAck), 24'h1);
        for (k = 0; k < 300 && nW < 4; k++) @(posedge clk_sys);
        check("write count", 24'(nW), 24'h4);
        // Self-calls have filled the stack; a new request must stay pending
        repeat (100) @(posedge clk_sys);
        irqReq <= 1'b0;
        repeat (8) @(posedge clk_sys);
        irqReq <= 1'b1;
        repeat (8) @(posedge clk_sys);
        regRead(`CPS_REG_PCSTAT, 16'h8000, 16'h8000);
        repeat (40) @(posedge clk_sys);
        check("ack count", 24'(nAck), 24'h1);
        summarize();
    end
endmodule
`default_nettype wire
